// *** rpmc_pkg.sv ***
// Constants, field positions and types for the root port perf/misc control bank.
// Assumes a 32-bit AHB-Lite register bus and 64-byte cache lines on the read path.
package rpmc_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets (each 64-bit register is two words)
	// ----------------------------------------------------------------
	localparam logic [11:0] RPMC_PERF_LO_OFS = 12'h180; // perf_control_status [31:0]
	localparam logic [11:0] RPMC_PERF_HI_OFS = 12'h184; // perf_control_status [63:32]
	localparam logic [11:0] RPMC_MISC_LO_OFS = 12'h188; // misc_control_status [31:0]
	localparam logic [11:0] RPMC_MISC_HI_OFS = 12'h18c; // misc_control_status [63:32]
	localparam logic [11:0] RPMC_IRQ_STAT_OFS = 12'h190; // Sticky event status
	localparam logic [11:0] RPMC_IRQ_MASK_OFS = 12'h194; // Event mask

	// ----------------------------------------------------------------
	// perf_control_status fields (low word)
	// ----------------------------------------------------------------
	localparam int RPMC_PERF_RSV0_BIT = 0; // Reserved, reads 1
	localparam int RPMC_PERF_LRG_BIT = 1; // Large read mode
	localparam int RPMC_PERF_NS_BIT = 2; // No-snoop read optimization
	localparam int RPMC_PERF_RSV3_BIT = 3; // Reserved, reads 0
	localparam int RPMC_PERF_ILV_BIT = 4; // Read interleave size
	localparam logic RPMC_PERF_RSV0_RST = 1'b1;
	localparam logic RPMC_PERF_LRG_RST = 1'b0;
	localparam logic RPMC_PERF_NS_RST = 1'b0;
	localparam logic RPMC_PERF_RSV3_RST = 1'b0;
	localparam logic RPMC_PERF_ILV_RST = 1'b1;

	// ----------------------------------------------------------------
	// misc_control_status fields (bit numbers of the 64-bit register)
	// ----------------------------------------------------------------
	localparam int RPMC_HI_BASE = 32; // First bit of the high word
	localparam int RPMC_MISC_PME_BIT = 48; // Turn-off ack received / timed out
	localparam int RPMC_MISC_FF_BIT = 36; // Form factor
	localparam int RPMC_MISC_OVF_BIT = 35; // Fatal override
	localparam int RPMC_MISC_OVN_BIT = 34; // Non-fatal override
	localparam int RPMC_MISC_OVC_BIT = 33; // Correctable override
	localparam logic RPMC_MISC_PME_RST = 1'b0;
	localparam logic RPMC_MISC_FF_RST = 1'b0;
	localparam logic [2:0] RPMC_MISC_OV_RST = 3'h0; // {fatal, nonfatal, corr}

	// ----------------------------------------------------------------
	// Interrupt status / mask layout
	// ----------------------------------------------------------------
	localparam int RPMC_IRQ_W = 4;
	localparam int RPMC_IRQ_PME = 0; // Turn-off ack event
	localparam int RPMC_IRQ_ERR0 = 1; // Forwarded corr, nonfatal, fatal at 1..3
	localparam logic [3:0] RPMC_IRQ_RST = 4'h0;

	// ----------------------------------------------------------------
	// Read queue interleave counts
	// ----------------------------------------------------------------
	localparam int RPMC_CL_BYTES = 64;
	localparam int RPMC_ILV_SMALL_BYTES = 128;
	localparam int RPMC_ILV_LARGE_BYTES = 256;
	localparam logic [2:0] RPMC_ILV_SMALL_LINES = 3'(RPMC_ILV_SMALL_BYTES / RPMC_CL_BYTES);
	localparam logic [2:0] RPMC_ILV_LARGE_LINES = 3'(RPMC_ILV_LARGE_BYTES / RPMC_CL_BYTES);

	// ----------------------------------------------------------------
	// Bus and state types
	// ----------------------------------------------------------------
	localparam logic [2:0] RPMC_HSIZE_WORD = 3'h2;
	typedef enum logic [1:0] {
		RPMC_ARB_SMALL = 2'b01,
		RPMC_ARB_LARGE = 2'b10
	} rpmc_arb_t;
endpackage

// *** rpmc_tb.sv ***
// Self-checking bench for the root port perf/misc control bank.
// Assumes rpmc_top with its in-file assertions; bench is the only AHB-Lite master.
`timescale 1ns/1ps
module testbench import rpmc_pkg::*;;
	// ----------------------------------------------------------------
	// Stimulus and observation signals
	// ----------------------------------------------------------------
	logic hclk = 1'b0; // 250 MHz clock
	logic hresetn = 1'b0; // Reset, active low
	logic ce = 1'b1, hsel = 1'b0, hwrite = 1'b0; // Bus controls
	logic [11:0] haddr = 12'h0; // Byte address
	logic [1:0] htrans = 2'h0; // Idle at start
	logic [2:0] hsize = 3'h2; // Word transfers only
	logic [31:0] hwdata = 32'h0, rd; // Write data, read result
	logic hreadyout, hresp; // Slave answer
	logic [31:0] hrdata; // Read data
	logic small_rd_pending = 1'b0, large_rd_pending = 1'b0, rd_line_done = 1'b0;
	logic grant_small_q, grant_large_q; // Arbiter grants
	logic rd_req_valid = 1'b0, rd_req_ns = 1'b0, rd_snoop_req, rd_nosnoop_req;
	logic pme_to_ack_rcvd = 1'b0, pme_to_timeout = 1'b0; // Turn-off events
	logic hp_serial_bit6 = 1'b0, retention_latch_sensor, electromech_latch_status;
	logic form_factor_server_io_module; // Form factor view
	logic [2:0] errs = 3'h0; // {fatal, nonfatal, corr} pulses
	logic [2:0] root_control_setting = 3'h0; // Root enables
	logic [2:0] core_err; // Forwarded errors
	logic irq; // Level interrupt
	int fails = 0, check_count = 0; // Verdict counters
	int n; // Scratch count

	// Ordinary case row: inputs then expected outputs
	typedef struct packed {
		logic [2:0] ovr, rcs, err;
		logic opt, ns;
		logic [2:0] exp_core;
		logic exp_nsp;
	} rpmc_tb_row_t;
	rpmc_tb_row_t rows [8] = '{
		'{3'h0, 3'h0, 3'h7, 1'b0, 1'b1, 3'h0, 1'b0},
		'{3'h4, 3'h0, 3'h7, 1'b1, 1'b1, 3'h4, 1'b1},
		'{3'h2, 3'h0, 3'h7, 1'b1, 1'b0, 3'h2, 1'b0},
		'{3'h1, 3'h0, 3'h7, 1'b0, 1'b0, 3'h1, 1'b0},
		'{3'h0, 3'h5, 3'h7, 1'b1, 1'b1, 3'h5, 1'b1},
		'{3'h6, 3'h1, 3'h3, 1'b0, 1'b1, 3'h3, 1'b0},
		'{3'h7, 3'h0, 3'h4, 1'b1, 1'b1, 3'h4, 1'b1},
		'{3'h0, 3'h2, 3'h5, 1'b1, 1'b0, 3'h0, 1'b0}};

	// ----------------------------------------------------------------
	// Clock, design instance
	// ----------------------------------------------------------------
	always #2 hclk = ~hclk;

	rpmc_top rpmc_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.small_rd_pending(small_rd_pending), .large_rd_pending(large_rd_pending),
		.rd_line_done(rd_line_done), .grant_small_q(grant_small_q),
		.grant_large_q(grant_large_q), .rd_req_valid(rd_req_valid), .rd_req_ns(rd_req_ns),
		.rd_snoop_req(rd_snoop_req), .rd_nosnoop_req(rd_nosnoop_req),
		.pme_to_ack_rcvd(pme_to_ack_rcvd), .pme_to_timeout(pme_to_timeout),
		.hp_serial_bit6(hp_serial_bit6), .retention_latch_sensor(retention_latch_sensor),
		.electromech_latch_status(electromech_latch_status),
		.form_factor_server_io_module(form_factor_server_io_module), .err_fatal(errs[2]), .err_nonfatal(errs[1]),
		.err_corr(errs[0]), .root_control_setting(root_control_setting),
		.core_err_fatal(core_err[2]), .core_err_nonfatal(core_err[1]),
		.core_err_corr(core_err[0]), .irq(irq));

	// ----------------------------------------------------------------
	// Compare, verdict and bus tasks
	// ----------------------------------------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t word got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t bit got %b expected %b", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (fails == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Bounded wait for an edge that samples hready high
	task automatic wait_ready();
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k < 100) begin
			@(posedge hclk);
			k++;
		end
		// A slave that never answers counts as a mismatch
		if (hreadyout !== 1'b1) begin
			fails++;
			$display("[ERR] %0t bus wait limit reached", $time);
		end
	endtask

	// One single word transfer; the address phase is held until hready
	task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= RPMC_HSIZE_WORD;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
		chk_bit(hresp, 1'b0); // Always OKAY
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb_xfer(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		ahb_xfer(1'b0, a, 32'h0, q);
		chk_word(q, exp);
	endtask

	// Lines served with both queues pending until the grant moves
	task automatic turn_len(input int exp);
		logic g0;
		int k;
		g0 = grant_small_q;
		k = 0;
		while (grant_small_q === g0 && k < 8) begin
			@(posedge hclk) rd_line_done <= 1'b1;
			@(posedge hclk) rd_line_done <= 1'b0;
			repeat (2) @(posedge hclk);
			#1;
			k++;
		end
		chk_word(32'(k), 32'(exp));
		chk_bit(grant_small_q ^ grant_large_q, 1'b1); // Exactly one grant
	endtask

	task automatic do_reset();
		@(posedge hclk) hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
	endtask

	// ----------------------------------------------------------------
	// Watchdog: far beyond the few hundred cycles the run needs
	// ----------------------------------------------------------------
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		do_reset();
		rd_chk(RPMC_PERF_LO_OFS, 32'h11);
		rd_chk(RPMC_PERF_HI_OFS, 32'h0);
		rd_chk(RPMC_MISC_LO_OFS, 32'h0);
		rd_chk(RPMC_MISC_HI_OFS, 32'h0);
		rd_chk(12'h1a0, 32'h0); // Unmapped reads zero
		chk_bit(grant_small_q, 1'b1);
		// Arbiter turn lengths for each mode pair
		small_rd_pending <= 1'b1;
		large_rd_pending <= 1'b1;
		turn_len(4);
		turn_len(4);
		wr(RPMC_PERF_LO_OFS, 32'h01);
		turn_len(2);
		turn_len(2);
		wr(RPMC_PERF_LO_OFS, 32'h03);
		turn_len(4);
		wr(RPMC_PERF_LO_OFS, 32'h13);
		turn_len(4);
		// Ordinary cases: overrides, root enables, no-snoop qualifier
		rd_req_valid <= 1'b1;
		foreach (rows[i]) begin
			wr(RPMC_MISC_HI_OFS, {28'h0, rows[i].ovr, 1'b0});
			wr(RPMC_PERF_LO_OFS, {27'h0, 1'b1, 1'b0, rows[i].opt, 1'b0, 1'b1});
			rd_chk(RPMC_MISC_HI_OFS, {28'h0, rows[i].ovr, 1'b0});
			@(posedge hclk);
			rd_req_ns <= rows[i].ns;
			root_control_setting <= rows[i].rcs;
			errs <= rows[i].err;
			@(posedge hclk) errs <= 3'h0;
			#1;
			chk_word({29'h0, core_err}, {29'h0, rows[i].exp_core});
			chk_bit(rd_nosnoop_req, rows[i].exp_nsp);
			chk_bit(rd_snoop_req, ~rows[i].exp_nsp);
		end
		rd_req_valid <= 1'b0;
		// Reserved bits and unmapped writes
		wr(RPMC_PERF_LO_OFS, 32'hffffffff);
		rd_chk(RPMC_PERF_LO_OFS, 32'h17);
		wr(RPMC_PERF_LO_OFS, 32'h0);
		rd_chk(RPMC_PERF_LO_OFS, 32'h01);
		wr(RPMC_PERF_HI_OFS, 32'hffffffff);
		rd_chk(RPMC_PERF_HI_OFS, 32'h0);
		wr(RPMC_MISC_HI_OFS, 32'hffffffff);
		rd_chk(RPMC_MISC_HI_OFS, 32'h1e);
		wr(RPMC_MISC_HI_OFS, 32'h0);
		wr(12'h1a0, 32'hffffffff);
		rd_chk(12'h1a0, 32'h0);
		// Turn-off ack and timeout events, sticky status, mask, interrupt
		wr(RPMC_IRQ_STAT_OFS, 32'hf);
		rd_chk(RPMC_IRQ_STAT_OFS, 32'h0);
		@(posedge hclk) pme_to_ack_rcvd <= 1'b1;
		@(posedge hclk) pme_to_ack_rcvd <= 1'b0;
		rd_chk(RPMC_MISC_HI_OFS, 32'h10000);
		rd_chk(RPMC_IRQ_STAT_OFS, 32'h1);
		chk_bit(irq, 1'b0);
		wr(RPMC_IRQ_MASK_OFS, 32'h1);
		rd_chk(RPMC_IRQ_MASK_OFS, 32'h1);
		chk_bit(irq, 1'b1);
		wr(RPMC_MISC_HI_OFS, 32'h10000);
		rd_chk(RPMC_MISC_HI_OFS, 32'h0);
		chk_bit(irq, 1'b1);
		wr(RPMC_IRQ_STAT_OFS, 32'h1);
		#1;
		chk_bit(irq, 1'b0);
		@(posedge hclk) pme_to_timeout <= 1'b1;
		@(posedge hclk) pme_to_timeout <= 1'b0;
		rd_chk(RPMC_MISC_HI_OFS, 32'h10000);
		chk_bit(irq, 1'b1);
		wr(RPMC_IRQ_MASK_OFS, 32'h0);
		#1;
		chk_bit(irq, 1'b0);
		// Form factor selects the latch view of serial bit 6
		@(posedge hclk) hp_serial_bit6 <= 1'b1;
		repeat (2) @(posedge hclk);
		#1;
		chk_bit(form_factor_server_io_module, 1'b0);
		chk_bit(retention_latch_sensor, 1'b1);
		@(posedge hclk) hp_serial_bit6 <= 1'b0;
		wr(RPMC_MISC_HI_OFS, 32'h10);
		#1;
		chk_bit(form_factor_server_io_module, 1'b1);
		@(posedge hclk) hp_serial_bit6 <= 1'b1;
		repeat (2) @(posedge hclk);
		#1;
		chk_bit(electromech_latch_status, 1'b1);
		chk_bit(retention_latch_sensor, 1'b0);
		// Clock enable low stalls the bus and drops a turn-off ack pulse
		wr(RPMC_MISC_HI_OFS, 32'h10010);
		@(posedge hclk) ce <= 1'b0;
		pme_to_ack_rcvd <= 1'b1;
		@(posedge hclk) pme_to_ack_rcvd <= 1'b0;
		#1;
		chk_bit(hreadyout, 1'b0);
		@(posedge hclk) ce <= 1'b1;
		rd_chk(RPMC_MISC_HI_OFS, 32'h10);
		// Second reset in mid-run restores defaults
		do_reset();
		rd_chk(RPMC_PERF_LO_OFS, 32'h11);
		rd_chk(RPMC_MISC_HI_OFS, 32'h0);
		chk_bit(irq, 1'b0);
		report_and_stop();
	end
endmodule

// *** rpmc_top.sv ***
// Root port perf/misc control bank: AHB-Lite registers, read queue arbiter,
// no-snoop qualifier, turn-off ack status, hot-plug latch decode, error escalation.
// Assumes all inputs are synchronous to hclk and event inputs are one-cycle pulses.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps

module rpmc_top import rpmc_pkg::*; (
	input wire logic hclk, // 250 MHz core clock
	input wire logic hresetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic hsel, // AHB slave select
	input wire logic [11:0] haddr, // AHB byte address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic hready, // AHB bus ready
	input wire logic [31:0] hwdata, // AHB write data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	output logic [31:0] hrdata, // AHB read data
	input wire logic small_rd_pending, // Small-request read queue not empty
	input wire logic large_rd_pending, // Large-request read queue not empty
	input wire logic rd_line_done, // One cache line served from granted queue
	output logic grant_small_q, // Small queue is being served
	output logic grant_large_q, // Large queue is being served
	input wire logic rd_req_valid, // Inbound memory read presented
	input wire logic rd_req_ns, // Read carries no-snoop attribute
	output logic rd_snoop_req, // Read must be snooped
	output logic rd_nosnoop_req, // Read goes straight to memory
	input wire logic pme_to_ack_rcvd, // Turn-off ack packet received
	input wire logic pme_to_timeout, // Wait for turn-off ack timed out
	input wire logic hp_serial_bit6, // Bit 6 of hot-plug serial stream
	output logic retention_latch_sensor, // Bit 6 as retention latch sensor
	output logic electromech_latch_status, // Bit 6 as electromech latch status
	output logic form_factor_server_io_module, // Slot is a server I/O module
	input wire logic err_fatal, // Fatal error at primary side
	input wire logic err_nonfatal, // Non-fatal error at primary side
	input wire logic err_corr, // Correctable error at primary side
	input wire logic [2:0] root_control_setting, // {fatal, nonfatal, corr} enables
	output logic core_err_fatal, // Fatal error to core error logic
	output logic core_err_nonfatal, // Non-fatal error to core error logic
	output logic core_err_corr, // Correctable error to core error logic
	output logic irq // Level interrupt
);
	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic wr_pend_r; // Write data phase pending
	logic [11:0] wr_addr_r; // Latched write address
	logic [31:0] hrdata_r; // Registered read data
	logic [31:0] rd_mux; // Read value at address phase
	logic addr_ok; // Valid address phase this cycle
	logic perf_ilv_r, perf_ns_r, perf_lrg_r; // perf_control_status fields
	logic misc_pme_r, misc_ff_r; // misc status and form factor
	logic [2:0] misc_ov_r; // Overrides {fatal, nonfatal, corr}
	logic [RPMC_IRQ_W-1:0] irq_stat_r, irq_mask_r; // Interrupt registers
	logic [RPMC_IRQ_W-1:0] irq_set; // Events this cycle
	logic wr_perf_lo, wr_misc_hi, wr_stat, wr_mask; // Write strobes
	logic pme_evt; // Turn-off ack or timeout

	// Zero wait states; ce low stalls the bus so no transfer is lost
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign addr_ok = ce && hsel && hready && htrans[1];

	// Read mux; unmapped addresses and reserved bits read as zero, except perf bit 0 which reads 1
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr)
			RPMC_PERF_LO_OFS: begin
				rd_mux[RPMC_PERF_RSV0_BIT] = RPMC_PERF_RSV0_RST;
				rd_mux[RPMC_PERF_LRG_BIT] = perf_lrg_r;
				rd_mux[RPMC_PERF_NS_BIT] = perf_ns_r;
				rd_mux[RPMC_PERF_RSV3_BIT] = RPMC_PERF_RSV3_RST;
				rd_mux[RPMC_PERF_ILV_BIT] = perf_ilv_r;
			end
			RPMC_MISC_HI_OFS: begin
				rd_mux[RPMC_MISC_PME_BIT-RPMC_HI_BASE] = misc_pme_r;
				rd_mux[RPMC_MISC_FF_BIT-RPMC_HI_BASE] = misc_ff_r;
				rd_mux[RPMC_MISC_OVF_BIT-RPMC_HI_BASE] = misc_ov_r[2];
				rd_mux[RPMC_MISC_OVN_BIT-RPMC_HI_BASE] = misc_ov_r[1];
				rd_mux[RPMC_MISC_OVC_BIT-RPMC_HI_BASE] = misc_ov_r[0];
			end
			RPMC_IRQ_STAT_OFS: rd_mux[RPMC_IRQ_W-1:0] = irq_stat_r;
			RPMC_IRQ_MASK_OFS: rd_mux[RPMC_IRQ_W-1:0] = irq_mask_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Address phase capture; read data sampled here, so a read right
	// after a write to the same word shows the old value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			hrdata_r <= 32'h0000_0000;
		end else if (ce) begin
			wr_pend_r <= addr_ok && hwrite && (hsize == RPMC_HSIZE_WORD);
			wr_addr_r <= haddr;
			if (addr_ok && !hwrite) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	// Data phase write strobes
	assign wr_perf_lo = ce && wr_pend_r && (wr_addr_r == RPMC_PERF_LO_OFS);
	assign wr_misc_hi = ce && wr_pend_r && (wr_addr_r == RPMC_MISC_HI_OFS);
	assign wr_stat = ce && wr_pend_r && (wr_addr_r == RPMC_IRQ_STAT_OFS);
	assign wr_mask = ce && wr_pend_r && (wr_addr_r == RPMC_IRQ_MASK_OFS);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// perf fields; reserved bits 0 and 3 have no storage at all
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			perf_ilv_r <= RPMC_PERF_ILV_RST;
			perf_ns_r <= RPMC_PERF_NS_RST;
			perf_lrg_r <= RPMC_PERF_LRG_RST;
		end else if (wr_perf_lo) begin
			perf_ilv_r <= hwdata[RPMC_PERF_ILV_BIT];
			perf_ns_r <= hwdata[RPMC_PERF_NS_BIT];
			perf_lrg_r <= hwdata[RPMC_PERF_LRG_BIT];
		end
	end

	// Form factor and error overrides; sticky kinds share the one reset here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			misc_ff_r <= RPMC_MISC_FF_RST;
			misc_ov_r <= RPMC_MISC_OV_RST;
		end else if (wr_misc_hi) begin
			misc_ff_r <= hwdata[RPMC_MISC_FF_BIT-RPMC_HI_BASE];
			misc_ov_r <= {hwdata[RPMC_MISC_OVF_BIT-RPMC_HI_BASE],
				hwdata[RPMC_MISC_OVN_BIT-RPMC_HI_BASE],
				hwdata[RPMC_MISC_OVC_BIT-RPMC_HI_BASE]};
		end
	end

	// Turn-off ack status: set wins over a same-cycle write-1-clear
	assign pme_evt = pme_to_ack_rcvd || pme_to_timeout;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			misc_pme_r <= RPMC_MISC_PME_RST;
		end else if (ce) begin
			if (pme_evt) begin
				misc_pme_r <= 1'b1;
			end else if (wr_misc_hi && hwdata[RPMC_MISC_PME_BIT-RPMC_HI_BASE]) begin
				misc_pme_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign irq_set = {core_err_fatal, core_err_nonfatal, core_err_corr, pme_evt};

	// Sticky status, events beat the write-1-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_r <= RPMC_IRQ_RST;
			irq_mask_r <= RPMC_IRQ_RST;
		end else if (ce) begin
			irq_stat_r <= irq_set | (irq_stat_r & ~({RPMC_IRQ_W{wr_stat}} & hwdata[RPMC_IRQ_W-1:0]));
			if (wr_mask) begin
				irq_mask_r <= hwdata[RPMC_IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irq_stat_r & irq_mask_r);

	// ----------------------------------------------------------------
	// Read queue interleave
	// ----------------------------------------------------------------
	rpmc_arb_t arb_r; // Queue being served
	logic [2:0] line_cnt_r; // Lines served in this turn
	logic [2:0] turn_lines; // Lines per turn
	logic other_pending, cur_pending, turn_end; // Switch terms

	// Large-read mode fixes the wider turn and ignores the size bit
	assign turn_lines = (perf_lrg_r || perf_ilv_r) ? RPMC_ILV_LARGE_LINES : RPMC_ILV_SMALL_LINES;
	assign cur_pending = (arb_r == RPMC_ARB_SMALL) ? small_rd_pending : large_rd_pending;
	assign other_pending = (arb_r == RPMC_ARB_SMALL) ? large_rd_pending : small_rd_pending;
	assign turn_end = rd_line_done && (line_cnt_r + 3'h1 >= turn_lines);

	// Switch after a full turn, or early when our queue ran dry
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			arb_r <= RPMC_ARB_SMALL;
			line_cnt_r <= 3'h0;
		end else if (ce) begin
			if (other_pending && (turn_end || (!cur_pending && !rd_line_done))) begin
				line_cnt_r <= 3'h0;
				unique case (arb_r)
					RPMC_ARB_SMALL: arb_r <= RPMC_ARB_LARGE;
					RPMC_ARB_LARGE: arb_r <= RPMC_ARB_SMALL;
				endcase
			end else if (turn_end) begin
				line_cnt_r <= 3'h0; // Nobody waiting, start a new turn
			end else if (rd_line_done) begin
				line_cnt_r <= line_cnt_r + 3'h1;
			end
		end
	end
	assign grant_small_q = (arb_r == RPMC_ARB_SMALL);
	assign grant_large_q = (arb_r == RPMC_ARB_LARGE);

	// ----------------------------------------------------------------
	// No-snoop qualifier (no handshake, combinational)
	// ----------------------------------------------------------------
	assign rd_nosnoop_req = rd_req_valid && rd_req_ns && perf_ns_r;
	assign rd_snoop_req = rd_req_valid && !(rd_req_ns && perf_ns_r);

	// ----------------------------------------------------------------
	// Hot-plug latch decode and error escalation
	// ----------------------------------------------------------------
	logic rls_r, ems_r; // Decoded latch bits
	logic [2:0] err_in; // {fatal, nonfatal, corr}
	logic [2:0] core_err_r; // Forwarded errors

	// Only the decode that matches the slot follows bit 6
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rls_r <= 1'b0;
			ems_r <= 1'b0;
		end else if (ce) begin
			rls_r <= misc_ff_r ? rls_r : hp_serial_bit6;
			ems_r <= misc_ff_r ? hp_serial_bit6 : ems_r;
		end
	end
	assign retention_latch_sensor = rls_r;
	assign electromech_latch_status = ems_r;
	assign form_factor_server_io_module = misc_ff_r;

	assign err_in = {err_fatal, err_nonfatal, err_corr};
	// One forwarding gate per error class
	for (genvar g = 0; g < 3; g++) begin : g_err
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				core_err_r[g] <= 1'b0;
			end else if (ce) begin
				core_err_r[g] <= err_in[g] && (misc_ov_r[g] || root_control_setting[g]);
			end
		end
	end
	assign core_err_fatal = core_err_r[2];
	assign core_err_nonfatal = core_err_r[1];
	assign core_err_corr = core_err_r[0];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_ilv_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && perf_lrg_r && !perf_ilv_r && rd_line_done && line_cnt_r == 3'h1 && cur_pending)
		|=> arb_r == $past(arb_r) && line_cnt_r == 3'h2)
		else $error("interleave size not ignored in large mode");
	chk_ilv_128_switch: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && !perf_lrg_r && !perf_ilv_r && rd_line_done && line_cnt_r == 3'h1 && other_pending)
		|=> arb_r != $past(arb_r))
		else $error("no queue switch after two lines");
	chk_ilv_256_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && perf_ilv_r && rd_line_done && line_cnt_r == 3'h1 && cur_pending)
		|=> arb_r == $past(arb_r) && line_cnt_r == 3'h2)
		else $error("256B turn ended after two lines");
	chk_nosnoop_path: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_req_valid |-> (rd_nosnoop_req == (rd_req_ns && perf_ns_r)) && (rd_snoop_req != rd_nosnoop_req))
		else $error("no-snoop routing wrong");
	chk_pme_set: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && pme_evt) |=> misc_pme_r && irq_stat_r[RPMC_IRQ_PME])
		else $error("turn-off ack status not set");
	chk_pme_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		(misc_pme_r && !wr_misc_hi) |=> misc_pme_r)
		else $error("turn-off ack status lost");
	chk_ff_decode: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && $stable(misc_ff_r) && !misc_ff_r) |=> retention_latch_sensor == $past(hp_serial_bit6)
		&& $stable(electromech_latch_status))
		else $error("card edge decode wrong");
	chk_err_fatal: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && err_fatal && misc_ov_r[2]) |=> core_err_fatal)
		else $error("fatal override not forwarded");
	chk_err_nonfatal: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && err_nonfatal && !misc_ov_r[1] && !root_control_setting[1]) |=> !core_err_nonfatal)
		else $error("non-fatal forwarded while disabled");
	chk_err_corr: assert property (@(posedge hclk) disable iff (!hresetn)
		(ce && err_corr) |=> core_err_corr == $past(misc_ov_r[0] || root_control_setting[0]))
		else $error("correctable forwarding wrong");
	chk_rsv_read: assert property (@(posedge hclk) disable iff (!hresetn)
		(addr_ok && !hwrite && haddr == RPMC_PERF_LO_OFS) |=> hrdata[RPMC_PERF_RSV0_BIT]
		&& !hrdata[RPMC_PERF_RSV3_BIT] && hrdata[31:5] == 27'h0)
		else $error("reserved perf bits wrong");
endmodule
